// File: common/dis_defs.vh
// Purpose: offsets, field positions and reset values of the converter
//          status and path configuration registers
// Assumes: byte-wide registers on the serial control port address space
// Notes:   included by its bare name
`ifndef DIS_DEFS_VH
`define DIS_DEFS_VH

// register offsets
`define DIS_ADDR_IRQ_FLAGS          8'h04
`define DIS_ADDR_CARRIER_ENABLES    8'h05
`define DIS_ADDR_PATH_SKIP          8'h06
`define DIS_ADDR_SHAPE_CONST        8'h07

// irq_flags bit positions
`define DIS_BIT_INPUT_CHECK_FAULT   7
`define DIS_BIT_SELF_TEST_FINISHED  6
`define DIS_BIT_UPDATE_REG_SET      5
`define DIS_BIT_UPDATE_REG_CLEARED  4
`define DIS_BIT_HANDOFF_GOOD        3
`define DIS_BIT_HANDOFF_DROPPED     2
`define DIS_BIT_OVERFLOW_CLIP       1

// carrier_enables fields
`define DIS_CARRIER_MSB             3
`define DIS_CARRIER_LSB             0

// path_skip_controls fields
`define DIS_BIT_MAPPER_SKIP         7
`define DIS_BIT_SHAPER_SKIP         6
`define DIS_INTERP_MSB              4
`define DIS_INTERP_LSB              0

// shaping_and_constellation fields
`define DIS_ROLLOFF_MSB             5
`define DIS_ROLLOFF_LSB             4
`define DIS_CONST_MSB               2
`define DIS_CONST_LSB               0
`define DIS_CONST_UNUSED            3'h7

// roll-off alpha in hundredths, one per code
`define DIS_ALPHA_CODE0             8'h0c
`define DIS_ALPHA_CODE1             8'h12
`define DIS_ALPHA_CODE2             8'h0f
`define DIS_ALPHA_CODE3             8'h0d

// reset values
`define DIS_RST_IRQ_FLAGS           7'h00
`define DIS_RST_CARRIER             4'h0
`define DIS_RST_INTERP              5'h00
`define DIS_RST_ROLLOFF             2'h0
`define DIS_RST_CONST               3'h0
`define DIS_RST_BYTE                8'h00

`endif

// File: hdl/dis_irq_path_cfg.v
// Purpose: interrupt status flags and datapath configuration registers
//          of the converter digital engine
// Assumes: register port driven by the serial control port engine, one
//          access per strobe, synchronous to clock
// Notes:   interrupt enable register lives elsewhere and arrives as a mask

`include "dis_defs.vh"

// Behaviour
// - parity error event sets flag bit 7; writing 1 clears it.
// - self-test terminal state sets flag bit 6; writing 1 clears it.
// - update register at 0x24 updated sets flag bit 5; write 1 clears.
// - update register cleared sets flag bit 4; writing 1 clears it.
// - flag bit 3 reads 1 while handoff works; no write clear.
// - loss of correct handoff sets flag bit 2; writing 1 clears it.
// - saturation overflow into 16x interpolator sets bit 1; write 1 clears.
// - each carrier enable bit turns its channel on; 0000 none, 1111 all.
// - bypass bit 7 routes data around the constellation mappers.
// - bypass bit 6 routes data around the shaping filters.
// - each interpolation bypass bit skips the filter of same index.
// - roll-off code picks alpha 0.12, 0.18, 0.15, 0.13.
// - constellation_select code picks constellation; code 111 is unused, never set.
// - enabled raised flag sets its status bit and pulls request low.
module dis_irq_path_cfg (
    // clock, reset, enable
    input  wire       clock,
    input  wire       rst_n,
    input  wire       clockEnable,
    // register port
    input  wire [7:0] regAddr,
    input  wire       regWrite,
    input  wire [7:0] regWriteData,
    input  wire       regRead,
    output reg  [7:0] regReadData,
    // status events from the datapath
    input  wire       parityErrorEvent,
    input  wire       selfTestDoneEvent,
    input  wire       updateRegSetEvent,
    input  wire       updateRegClearEvent,
    input  wire       handoffGood,
    input  wire       handoffLostEvent,
    input  wire       overflowEvent,
    // interrupt enable mask and request
    input  wire [7:0] irqEnableMask,
    output wire       irqRequest_n,
    // datapath configuration
    output reg  [3:0] carrierOnMask,
    output reg        mapperBypass,
    output reg        shaperBypass,
    output reg  [4:0] interpBypass,
    output reg  [1:0] rollOffSelect,
    output reg  [7:0] rollOffAlpha,
    output reg  [2:0] constellationSelect,
    output wire       constellationValid
);

    // sticky flags, bits 7..1 of irq_flags (bit 3 unused here)
    reg  [7:1] stickyFlags;
    reg        handoffGoodFlag;
    reg  [7:1] next_stickyFlags;
    reg  [7:1] eventVector;
    reg  [7:1] clearVector;
    reg  [7:0] flagsView;
    reg  [7:0] next_readData;
    reg  [7:0] next_alpha;

    wire writeFlags  = regWrite && (regAddr == `DIS_ADDR_IRQ_FLAGS);
    wire writeCarier = regWrite && (regAddr == `DIS_ADDR_CARRIER_ENABLES);
    wire writeSkip   = regWrite && (regAddr == `DIS_ADDR_PATH_SKIP);
    wire writeShape  = regWrite && (regAddr == `DIS_ADDR_SHAPE_CONST);

    // gather the enabled events into flag positions
    always @* begin
        eventVector = 7'h00;
        eventVector[`DIS_BIT_INPUT_CHECK_FAULT]  = parityErrorEvent &
            irqEnableMask[`DIS_BIT_INPUT_CHECK_FAULT];
        eventVector[`DIS_BIT_SELF_TEST_FINISHED] = selfTestDoneEvent &
            irqEnableMask[`DIS_BIT_SELF_TEST_FINISHED];
        eventVector[`DIS_BIT_UPDATE_REG_SET]     = updateRegSetEvent &
            irqEnableMask[`DIS_BIT_UPDATE_REG_SET];
        eventVector[`DIS_BIT_UPDATE_REG_CLEARED] = updateRegClearEvent &
            irqEnableMask[`DIS_BIT_UPDATE_REG_CLEARED];
        eventVector[`DIS_BIT_HANDOFF_DROPPED]    = handoffLostEvent &
            irqEnableMask[`DIS_BIT_HANDOFF_DROPPED];
        eventVector[`DIS_BIT_OVERFLOW_CLIP]      = overflowEvent &
            irqEnableMask[`DIS_BIT_OVERFLOW_CLIP];
    end

    // write-one-to-clear mask; bit 3 has no clear and is a live level
    always @* begin
        clearVector = 7'h00;
        if (writeFlags) begin
            clearVector = regWriteData[7:1];
        end
        clearVector[`DIS_BIT_HANDOFF_GOOD] = 1'b0;
    end

    // set wins over a clear landing in the same cycle
    always @* begin
        next_stickyFlags = (stickyFlags & ~clearVector) | eventVector;
        next_stickyFlags[`DIS_BIT_HANDOFF_GOOD] = 1'b0;
    end

    // flag register and live handoff level
    always @(posedge clock) begin
        if (!rst_n) begin
            stickyFlags     <= `DIS_RST_IRQ_FLAGS;
            handoffGoodFlag <= 1'b0;
        end else if (clockEnable) begin
            stickyFlags     <= next_stickyFlags;
            handoffGoodFlag <= handoffGood &
                irqEnableMask[`DIS_BIT_HANDOFF_GOOD];
        end
    end

    // assembled read view of irq_flags; bit 0 reserved
    always @* begin
        flagsView = {stickyFlags, 1'b0};
        flagsView[`DIS_BIT_HANDOFF_GOOD] = handoffGoodFlag;
    end

    // request low while any flag bit stands
    assign irqRequest_n = ~(|flagsView);

    // carrier enable register, low nibble only
    always @(posedge clock) begin
        if (!rst_n) begin
            carrierOnMask <= `DIS_RST_CARRIER;
        end else if (clockEnable && writeCarier) begin
            carrierOnMask <=
                regWriteData[`DIS_CARRIER_MSB:`DIS_CARRIER_LSB];
        end
    end

    // bypass register, bit 5 is reserved and dropped
    always @(posedge clock) begin
        if (!rst_n) begin
            mapperBypass <= 1'b0;
            shaperBypass <= 1'b0;
            interpBypass <= `DIS_RST_INTERP;
        end else if (clockEnable && writeSkip) begin
            mapperBypass <= regWriteData[`DIS_BIT_MAPPER_SKIP];
            shaperBypass <= regWriteData[`DIS_BIT_SHAPER_SKIP];
            interpBypass <=
                regWriteData[`DIS_INTERP_MSB:`DIS_INTERP_LSB];
        end
    end

    // alpha in hundredths for the roll-off code
    always @* begin
        case (regWriteData[`DIS_ROLLOFF_MSB:`DIS_ROLLOFF_LSB])
            2'h0: next_alpha = `DIS_ALPHA_CODE0;
            2'h1: next_alpha = `DIS_ALPHA_CODE1;
            2'h2: next_alpha = `DIS_ALPHA_CODE2;
            default: next_alpha = `DIS_ALPHA_CODE3;
        endcase
    end

    // shaping and constellation register; the unused code is refused
    always @(posedge clock) begin
        if (!rst_n) begin
            rollOffSelect       <= `DIS_RST_ROLLOFF;
            rollOffAlpha        <= `DIS_ALPHA_CODE0;
            constellationSelect <= `DIS_RST_CONST;
        end else if (clockEnable && writeShape) begin
            rollOffSelect <=
                regWriteData[`DIS_ROLLOFF_MSB:`DIS_ROLLOFF_LSB];
            rollOffAlpha  <= next_alpha;
            if (regWriteData[`DIS_CONST_MSB:`DIS_CONST_LSB] != `DIS_CONST_UNUSED) begin
                constellationSelect <=
                    regWriteData[`DIS_CONST_MSB:`DIS_CONST_LSB];
            end
        end
    end

    // constellation_select code always holds a defined constellation
    assign constellationValid = (constellationSelect != `DIS_CONST_UNUSED);

    // read multiplexer; unmapped offsets read zero
    always @* begin
        if (regAddr == `DIS_ADDR_IRQ_FLAGS) begin
            next_readData = flagsView;
        end else if (regAddr == `DIS_ADDR_CARRIER_ENABLES) begin
            next_readData = {4'h0, carrierOnMask};
        end else if (regAddr == `DIS_ADDR_PATH_SKIP) begin
            next_readData = {mapperBypass, shaperBypass, 1'b0, interpBypass};
        end else if (regAddr == `DIS_ADDR_SHAPE_CONST) begin
            next_readData = {2'h0, rollOffSelect, 1'b0, constellationSelect};
        end else begin
            next_readData = `DIS_RST_BYTE;
        end
    end

    // read data is captured on the read strobe and held
    always @(posedge clock) begin
        if (!rst_n) begin
            regReadData <= `DIS_RST_BYTE;
        end else if (clockEnable && regRead) begin
            regReadData <= next_readData;
        end
    end

endmodule // dis_irq_path_cfg

// File: test/dis_irq_path_cfg_monitor.sv
// Purpose: port checks of the flag and config bank
// Assumes: clockEnable gates every update
// Notes: bound to the design top
module dis_irq_path_cfg_monitor (
    // clock and reset
    input wire logic       clock,
    input wire logic       rst_n,
    // register port
    input wire logic       clockEnable,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic [7:0] regWriteData,
    input wire logic       regRead,
    input wire logic [7:0] regReadData,
    // events and outputs
    input wire logic       parityErrorEvent,
    input wire logic       overflowEvent,
    input wire logic [7:0] irqEnableMask,
    input wire logic       irqRequest_n,
    input wire logic [3:0] carrierOnMask,
    input wire logic [1:0] rollOffSelect,
    input wire logic [7:0] rollOffAlpha,
    input wire logic       constellationValid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire rdEn = clockEnable && regRead;
    carrier_write_a: assert property (clockEnable && regWrite && regAddr == 8'h05
        |=> carrierOnMask == $past(regWriteData[3:0])) else $error("carrier mask not written");
    carrier_read_a: assert property (rdEn && regAddr == 8'h05
        |=> regReadData == {4'h0, $past(carrierOnMask)}) else $error("carrier readback wrong");
    alpha_map_a: assert property (rollOffAlpha == (rollOffSelect[0] ?
        (rollOffSelect[1] ? 8'h0d : 8'h12) : (rollOffSelect[1] ? 8'h0f : 8'h0c)))
        else $error("alpha does not match code");
    const_valid_a: assert property (constellationValid) else $error("constellation_select unused");
    overflow_irq_a: assert property (clockEnable && overflowEvent && irqEnableMask[1]
        |=> !irqRequest_n) else $error("overflow raised no request");
    parity_irq_a: assert property (clockEnable && parityErrorEvent && irqEnableMask[7]
        |=> !irqRequest_n) else $error("parity raised no request");
    unmapped_read_a: assert property (rdEn && (regAddr < 8'h04 || regAddr > 8'h07)
        |=> regReadData == 8'h00) else $error("unmapped read not zero");
    read_hold_a: assert property (!rdEn |=> $stable(regReadData))
        else $error("read data moved without read");
endmodule // dis_irq_path_cfg_monitor

bind dis_irq_path_cfg dis_irq_path_cfg_monitor i_mon (.*);

// File: test/dis_host_model.sv
// Purpose: register port host for the flag and config bank
// Assumes: one access per strobe, driven just after each edge
// Notes: released lines show the inverse of the last value
module dis_host_model (
    // clock
    input  wire logic       clock,
    // register port
    output logic      [7:0] regAddr = 8'h00,
    output logic            regWrite = 1'b0,
    output logic      [7:0] regWriteData = 8'h00,
    output logic            regRead = 1'b0,
    input  wire logic [7:0] regReadData
);
    timeunit 1ns;
    timeprecision 100ps;
    // one write strobe, taken at the following edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        regWriteData <= ~d;
    endtask
    // one read strobe, data registered at the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regReadData;
    endtask
endmodule // dis_host_model

// File: test/dis_irq_path_cfg_tb.sv
// Purpose: self-checking bench of the flag and config bank
// Assumes: inputs driven just after rising edges
// Notes: clockEnable held high throughout
module dis_irq_path_cfg_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, rst_n = 1'b0, clockEnable = 1'b1;
    logic [7:0] irqEnableMask = 8'hfe, evt = 8'h00, regAddr, regWriteData, regReadData, q;
    logic regWrite, regRead, irqRequest_n, mapperBypass, shaperBypass, constellationValid;
    logic [7:0] rollOffAlpha, alpha [4] = '{8'h0c, 8'h12, 8'h0f, 8'h0d};
    logic [3:0] carrierOnMask;
    logic [4:0] interpBypass;
    logic [1:0] rollOffSelect;
    logic [2:0] constellationSelect;
    int mismatches = 0, comparisons = 0, cycles = 0;
    always #50 clock = ~clock;
    dis_host_model i_host (.clock(clock), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData));
    dis_irq_path_cfg i_dut (.clock(clock), .rst_n(rst_n), .clockEnable(clockEnable),
        .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
        .regRead(regRead), .regReadData(regReadData), .parityErrorEvent(evt[7]),
        .selfTestDoneEvent(evt[6]), .updateRegSetEvent(evt[5]), .updateRegClearEvent(evt[4]),
        .handoffGood(evt[3]), .handoffLostEvent(evt[2]), .overflowEvent(evt[1]),
        .irqEnableMask(irqEnableMask), .irqRequest_n(irqRequest_n),
        .carrierOnMask(carrierOnMask), .mapperBypass(mapperBypass),
        .shaperBypass(shaperBypass), .interpBypass(interpBypass),
        .rollOffSelect(rollOffSelect), .rollOffAlpha(rollOffAlpha),
        .constellationSelect(constellationSelect), .constellationValid(constellationValid));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // reset values and unmapped places
    task automatic t_reset;
        for (int a = 3; a < 9; a++) begin
            i_host.rd(a[7:0], q);
            chk(q, 8'h00);
        end
    endtask
    // path controls, ascending filter bypass, reserved bits
    task automatic t_config;
        i_host.wr(8'h05, 8'hff);
        i_host.rd(8'h05, q);
        chk({4'h0, carrierOnMask}, 8'h0f);
        for (int i = 1; i < 6; i++) begin
            i_host.wr(8'h06, 8'he0 | ((8'h01 << i) - 8'h01));
            i_host.rd(8'h06, q);
            chk(q, 8'hc0 | ((8'h01 << i) - 8'h01));
        end
        chk({mapperBypass, shaperBypass, 1'b0, interpBypass}, 8'hdf);
        for (int m = 0; m < 7; m++) begin
            i_host.wr(8'h07, 8'hc8 | {2'b00, m[1:0], 1'b0, m[2:0]});
            i_host.rd(8'h07, q);
            chk(q, {2'b00, m[1:0], 1'b0, m[2:0]});
            chk(rollOffAlpha, alpha[m[1:0]]);
        end
        // unused constellation_select code is not stored, roll-off beside it still is
        i_host.wr(8'h07, 8'h37);
        i_host.rd(8'h07, q);
        chk(q, 8'h36);
        chk(rollOffAlpha, alpha[3]);
        chk({7'h00, constellationValid}, 8'h01);
    endtask
    // each flag raised and read, sticky ones cleared by a 1, live bit 3 stays set; then a masked event
    task automatic t_flags;
        for (int b = 1; b < 8; b++) begin
            @(posedge clock);
            evt[b] <= 1'b1;
            @(posedge clock);
            evt <= (b == 3) ? 8'h08 : 8'h00;
            #1;
            chk({7'h00, irqRequest_n}, 8'h00);
            i_host.rd(8'h04, q);
            chk(q, 8'h01 << b);
            i_host.wr(8'h04, 8'h01 << b);
            i_host.rd(8'h04, q);
            chk(q, (b == 3) ? 8'h08 : 8'h00);
            @(posedge clock);
            evt <= 8'h00;
        end
        @(posedge clock);
        irqEnableMask <= 8'h00;
        evt <= 8'h02;
        @(posedge clock);
        evt <= 8'h00;
        i_host.rd(8'h04, q);
        chk(q, 8'h00);
        chk({7'h00, irqRequest_n}, 8'h01);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // main sequence after 20 reset cycles
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_config();
        t_flags();
        tally_and_finish();
    end
    // cut a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end
endmodule // dis_irq_path_cfg_tb
